/* hw/pwt_defs.svh */
`ifndef PWT_DEFS_SVH
`define PWT_DEFS_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define PWT_A_CTRL 8'h00
`define PWT_A_TC 8'h04
`define PWT_A_PR 8'h08
`define PWT_A_PC 8'h0C
`define PWT_A_MCR 8'h10
`define PWT_A_CCR 8'h14
`define PWT_A_PCR 8'h18
`define PWT_A_LER 8'h1C
`define PWT_A_IST 8'h20
`define PWT_A_IMSK 8'h24
`define PWT_A_MR_HI 3'h2
`define PWT_A_CR_HI 3'h3
// ----------------------------------------
// field positions
// ----------------------------------------
`define PWT_CTRL_EN 0
`define PWT_CTRL_RST 1
`define PWT_CTRL_PWM 3
`define PWT_MCR_INT 0
`define PWT_MCR_RST 1
`define PWT_MCR_STP 2
`define PWT_CCR_RISE 0
`define PWT_CCR_FALL 1
`define PWT_CCR_INT 2
`define PWT_PCR_ENA 8
`define PWT_IST_CAP 8
// ----------------------------------------
// bus answers and reset values
// ----------------------------------------
`define PWT_RESP_OKAY 2'h0
`define PWT_RESP_SLVERR 2'h2
`define PWT_RST_WORD 32'h0000_0000
`endif

/* hw/pwt_pkg.sv */
package pwt_pkg;
    typedef logic [31:0] pwt_word_t;
    typedef logic [7:0] pwt_addr_t;
    typedef enum logic {PWT_HALT, PWT_RUN} pwt_run_t;
endpackage : pwt_pkg

/* hw/pwt_chan.sv */
`timescale 1ns/1ps
`default_nettype none
module pwt_chan (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic en,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    import pwt_pkg::*;
    // clear wins so an output whose edges coincide stays low
    always_ff @(posedge aclk) begin
        if (!aresetn || !en) begin
            q <= 1'b0;
        end else if (clr) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end
    end
endmodule : pwt_chan
`default_nettype wire

/* hw/pwt_axil.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pwt_defs.svh"
module pwt_axil (
    input wire logic aclk,
    input wire logic aresetn,
    input wire pwt_pkg::pwt_addr_t awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire pwt_pkg::pwt_word_t wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    output logic arready,
    output pwt_pkg::pwt_word_t rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_stb,
    output pwt_pkg::pwt_addr_t wr_addr,
    output pwt_pkg::pwt_word_t wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    input wire pwt_pkg::pwt_word_t rd_data,
    input wire logic rd_err
);
    import pwt_pkg::*;
    logic aw_full_reg;
    logic w_full_reg;
    assign awready = !aw_full_reg;
    assign wready = !w_full_reg;
    assign wr_stb = aw_full_reg && w_full_reg && !bvalid;
    assign arready = !rvalid;
    // ----------------------------------------
    // write address and data holding
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            wr_addr <= '0;
        end else if (awvalid && awready) begin
            aw_full_reg <= 1'b1;
            wr_addr <= awaddr;
        end else if (wr_stb) begin
            aw_full_reg <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            wr_data <= '0;
            wr_strb <= 4'h0;
        end else if (wvalid && wready) begin
            w_full_reg <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
        end else if (wr_stb) begin
            w_full_reg <= 1'b0;
        end
    end
    // ----------------------------------------
    // responses
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `PWT_RESP_OKAY;
        end else if (wr_stb) begin
            bvalid <= 1'b1;
            bresp <= wr_err ? `PWT_RESP_SLVERR : `PWT_RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `PWT_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_data;
            rresp <= rd_err ? `PWT_RESP_SLVERR : `PWT_RESP_OKAY;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : pwt_axil
`default_nettype wire

/* hw/pwt_top.sv */
// Contract
// - 32-bit counter counts clock cycles through a programmable 32-bit prescaler.
// - seven match registers serve single-edge, double-edge or mixed outputs.
// - in pwm mode match register 0 resets the counter, setting the shared cycle period.
// - single-edge output rises at cycle start, falls on its match; constant low never rises.
// - double-edge output uses two match registers for rising and falling edges.
// - rise before fall gives positive pulse, reversed order gives negative pulse.
// - each match may continue, stop or reset the counter, with optional interrupt.
// - in pwm mode new match values apply only at cycle start after software releases them; in timer mode writes apply at once.
// - four capture inputs save the counter on an edge, optional interrupt.
// - period and width are any count; all outputs share one rate.
// - without pwm mode the block is a plain timer with match and capture.
`timescale 1ns/1ps
`default_nettype none
`include "pwt_defs.svh"
module pwt_top #(
    parameter int N_MATCH = 7,
    parameter int N_CAP = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire pwt_pkg::pwt_addr_t s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire pwt_pkg::pwt_word_t s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire pwt_pkg::pwt_addr_t s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output pwt_pkg::pwt_word_t s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [N_CAP-1:0] cap_in,
    output logic [N_MATCH-2:0] pwm_out,
    output logic irq
);
    import pwt_pkg::*;

    if (N_MATCH < 3 || N_MATCH > 8 || N_CAP < 1 || N_CAP > 8) begin : g_chk
        $error("pwt_top: N_MATCH must be 3..8 and N_CAP 1..8");
    end

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic wr_stb, wr_err, rd_err, cnt_rst_reg, pwm_en_reg, tick, cycle_start;
    pwt_addr_t wr_addr;
    pwt_word_t wr_data, rd_data, bmask, wv, tc_reg, pc_reg, pr_reg;
    logic [3:0] wr_strb;
    pwt_run_t run_reg;
    logic [3*N_MATCH-1:0] mcr_reg;
    logic [3*N_CAP-1:0] ccr_reg;
    logic [N_MATCH-1:2] de_sel_reg;
    logic [N_MATCH-1:1] out_en_reg;
    logic [N_MATCH-1:0] ler_reg, hit, rst_hit, stp_hit;
    logic [N_MATCH-1:0][31:0] mr_reg, shd_reg;
    logic [N_CAP-1:0][31:0] cr_reg;
    logic [15:0] ist_reg, imsk_reg, ev;
    logic [N_CAP-1:0] cap_prev_reg, cap_ev;

    // ----------------------------------------
    // register map helpers
    // ----------------------------------------
    function automatic logic reg_ok(pwt_addr_t a);
        logic ok;
        ok = 1'b0;
        if (a[7:5] == `PWT_A_MR_HI) begin
            ok = int'(a[4:2]) < N_MATCH;
        end else if (a[7:5] == `PWT_A_CR_HI) begin
            ok = int'(a[4:2]) < N_CAP;
        end else begin
            ok = a <= `PWT_A_IMSK;
        end
        return ok && (a[1:0] == 2'h0);
    endfunction : reg_ok

    function automatic pwt_word_t reg_rd(pwt_addr_t a);
        pwt_word_t v;
        v = '0;
        if (a[7:5] == `PWT_A_MR_HI) begin
            if (int'(a[4:2]) < N_MATCH) begin
                v = shd_reg[a[4:2]];
            end
        end else if (a[7:5] == `PWT_A_CR_HI) begin
            if (int'(a[4:2]) < N_CAP) begin
                v = cr_reg[a[4:2]];
            end
        end else begin
            case (a)
                `PWT_A_CTRL: begin
                    v[`PWT_CTRL_EN] = (run_reg == PWT_RUN);
                    v[`PWT_CTRL_RST] = cnt_rst_reg;
                    v[`PWT_CTRL_PWM] = pwm_en_reg;
                end
                `PWT_A_TC: v = tc_reg;
                `PWT_A_PR: v = pr_reg;
                `PWT_A_PC: v = pc_reg;
                `PWT_A_MCR: v[3*N_MATCH-1:0] = mcr_reg;
                `PWT_A_CCR: v[3*N_CAP-1:0] = ccr_reg;
                `PWT_A_PCR: begin
                    v[N_MATCH-1:2] = de_sel_reg;
                    v[`PWT_PCR_ENA+N_MATCH-1:`PWT_PCR_ENA+1] = out_en_reg;
                end
                `PWT_A_LER: v[N_MATCH-1:0] = ler_reg;
                `PWT_A_IST: v[15:0] = ist_reg;
                `PWT_A_IMSK: v[15:0] = imsk_reg;
                default: v = '0;
            endcase
        end
        return v;
    endfunction : reg_rd

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    assign rd_data = reg_rd(s_axi_araddr);
    assign rd_err = !reg_ok(s_axi_araddr);
    assign wr_err = !reg_ok(wr_addr);
    assign bmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    assign wv = (wr_data & bmask) | (reg_rd(wr_addr) & ~bmask);

    pwt_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_reg <= PWT_HALT;
        end else if (|stp_hit) begin
            run_reg <= PWT_HALT;
        end else if (wr_stb && wr_addr == `PWT_A_CTRL) begin
            run_reg <= wv[`PWT_CTRL_EN] ? PWT_RUN : PWT_HALT;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_rst_reg <= 1'b0;
            pwm_en_reg <= 1'b0;
            pr_reg <= `PWT_RST_WORD;
            mcr_reg <= '0;
            ccr_reg <= '0;
            de_sel_reg <= '0;
            out_en_reg <= '0;
            imsk_reg <= 16'h0000;
        end else if (wr_stb) begin
            case (wr_addr)
                `PWT_A_CTRL: begin
                    cnt_rst_reg <= wv[`PWT_CTRL_RST];
                    pwm_en_reg <= wv[`PWT_CTRL_PWM];
                end
                `PWT_A_PR: pr_reg <= wv;
                `PWT_A_MCR: mcr_reg <= wv[3*N_MATCH-1:0];
                `PWT_A_CCR: ccr_reg <= wv[3*N_CAP-1:0];
                `PWT_A_PCR: begin
                    de_sel_reg <= wv[N_MATCH-1:2];
                    out_en_reg <= wv[`PWT_PCR_ENA+N_MATCH-1:`PWT_PCR_ENA+1];
                end
                `PWT_A_IMSK: imsk_reg <= wv[15:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // prescaler and counter
    // ----------------------------------------
    assign tick = (run_reg == PWT_RUN) && !cnt_rst_reg && (pc_reg == pr_reg);
    assign cycle_start = hit[0] && pwm_en_reg;

    for (genvar i = 0; i < N_MATCH; i++) begin : g_hit
        assign hit[i] = tick && (tc_reg == mr_reg[i]);
        if (i == 0) begin : g_per
            assign rst_hit[i] = hit[i] && (mcr_reg[`PWT_MCR_RST] || pwm_en_reg);
        end else begin : g_oth
            assign rst_hit[i] = hit[i] && mcr_reg[3*i+`PWT_MCR_RST];
        end
        assign stp_hit[i] = hit[i] && mcr_reg[3*i+`PWT_MCR_STP];
        assign ev[i] = hit[i] && mcr_reg[3*i+`PWT_MCR_INT];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || cnt_rst_reg) begin
            pc_reg <= `PWT_RST_WORD;
            tc_reg <= `PWT_RST_WORD;
        end else if (run_reg == PWT_RUN) begin
            if (tick) begin
                pc_reg <= `PWT_RST_WORD;
                tc_reg <= (|rst_hit) ? `PWT_RST_WORD : tc_reg + 32'h0000_0001;
            end else begin
                pc_reg <= pc_reg + 32'h0000_0001;
            end
        end
    end

    // ----------------------------------------
    // match registers with release at cycle start
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ler_reg <= '0;
        end else begin
            ler_reg <= (ler_reg & ~(cycle_start ? ler_reg : '0))
                | ((wr_stb && wr_addr == `PWT_A_LER) ? wv[N_MATCH-1:0] : '0);
        end
    end

    for (genvar i = 0; i < N_MATCH; i++) begin : g_mr
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                shd_reg[i] <= `PWT_RST_WORD;
                mr_reg[i] <= `PWT_RST_WORD;
            end else begin
                if (wr_stb && wr_addr[7:5] == `PWT_A_MR_HI && int'(wr_addr[4:2]) == i) begin
                    shd_reg[i] <= wv;
                    if (!pwm_en_reg) begin
                        mr_reg[i] <= wv;
                    end
                end
                if (cycle_start && ler_reg[i]) begin
                    mr_reg[i] <= shd_reg[i];
                end
            end
        end
    end

    // ----------------------------------------
    // capture inputs
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        cap_prev_reg <= cap_in;
    end

    for (genvar j = 0; j < N_CAP; j++) begin : g_cap
        assign cap_ev[j] = (cap_in[j] && !cap_prev_reg[j] && ccr_reg[3*j+`PWT_CCR_RISE])
            || (!cap_in[j] && cap_prev_reg[j] && ccr_reg[3*j+`PWT_CCR_FALL]);
        assign ev[`PWT_IST_CAP+j] = cap_ev[j] && ccr_reg[3*j+`PWT_CCR_INT];
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cr_reg[j] <= `PWT_RST_WORD;
            end else if (cap_ev[j]) begin
                cr_reg[j] <= tc_reg;
            end
        end
    end

    for (genvar k = N_MATCH; k < `PWT_IST_CAP; k++) begin : g_ev_m
        assign ev[k] = 1'b0;
    end
    for (genvar k = `PWT_IST_CAP + N_CAP; k < 16; k++) begin : g_ev_c
        assign ev[k] = 1'b0;
    end

    // ----------------------------------------
    // interrupt status, set wins over clear
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ist_reg <= 16'h0000;
        end else begin
            ist_reg <= (ist_reg & ~((wr_stb && wr_addr == `PWT_A_IST) ? wr_data[15:0] & bmask[15:0]
                : 16'h0000)) | ev;
        end
    end
    assign irq = |(ist_reg & imsk_reg);

    // ----------------------------------------
    // pwm outputs
    // ----------------------------------------
    for (genvar k = 1; k < N_MATCH; k++) begin : g_out
        logic set;
        if (k > 1) begin : g_de
            assign set = de_sel_reg[k] ? hit[k-1]
                : cycle_start && (mr_reg[k] != 32'h0000_0000);
        end else begin : g_se
            assign set = cycle_start && (mr_reg[k] != 32'h0000_0000);
        end
        pwt_chan u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .en(pwm_en_reg && out_en_reg[k]),
            .set(set),
            .clr(hit[k]),
            .q(pwm_out[k-1])
        );
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_count_step: assert property (
        tick && !(|rst_hit) |=> tc_reg == $past(tc_reg) + 32'h0000_0001 && pc_reg == 32'h0
    ) else $error("counter did not advance on prescale tick");
    a_period_wrap: assert property (
        cycle_start && !cnt_rst_reg |=> tc_reg == 32'h0000_0000
    ) else $error("period match did not reset counter");
    a_single_fall: assert property (
        hit[1] && pwm_en_reg |=> !pwm_out[0]
    ) else $error("single-edge output not low after its match");
    if (N_MATCH > 3) begin : g_a_low
        a_const_low: assert property (
            pwm_en_reg && !de_sel_reg[3] && mr_reg[3] == 32'h0 && !pwm_out[2] |=> !pwm_out[2]
        ) else $error("constant low output rose");
    end
    a_double_rise: assert property (
        pwm_en_reg && out_en_reg[2] && de_sel_reg[2] && hit[1] && !hit[2] |=> pwm_out[1]
    ) else $error("double-edge output missed rising match");
    a_stop_halt: assert property (
        |stp_hit |=> run_reg == PWT_HALT ##1 $stable(tc_reg)
    ) else $error("stop match did not halt counter");
    a_match_hold: assert property (
        pwm_en_reg && !cycle_start |=> $stable(mr_reg)
    ) else $error("active match changed outside cycle start");
    a_cap_value: assert property (
        cap_ev[0] |=> cr_reg[0] == $past(tc_reg)
    ) else $error("capture did not save counter");
    a_flag_sticky: assert property (
        ist_reg[0] && !(wr_stb && wr_addr == `PWT_A_IST) |=> ist_reg[0]
    ) else $error("status flag lost without clear");
    a_idle_low: assert property (
        !pwm_en_reg |=> pwm_out == '0
    ) else $error("pwm output high while pwm disabled");

    c_cycle: cover property (cycle_start ##[1:20] cycle_start);
    c_capture: cover property (cap_ev[0] && ev[`PWT_IST_CAP]);
    c_irq: cover property (!irq ##1 irq);
    c_stop: cover property (|stp_hit);
endmodule : pwt_top
`default_nettype wire

/* dv/pwt_load.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// load model: measures period, high time and rises of each pin
// ----------------------------------------
module pwt_load (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] pwm,
    output logic [5:0][7:0] per_w,
    output logic [5:0][7:0] hi_w,
    output logic [5:0][7:0] n_rise
);
    logic [5:0] prev;
    logic [5:0][7:0] cnt;
    logic [5:0][7:0] hc;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev <= '0;
            cnt <= '0;
            hc <= '0;
            per_w <= '0;
            hi_w <= '0;
            n_rise <= '0;
        end else begin
            prev <= pwm;
            for (int k = 0; k < 6; k++) begin
                cnt[k] <= cnt[k] + 8'h01;
                if (pwm[k]) hc[k] <= hc[k] + 8'h01;
                // shared repetition rate and widths seen at the pin
                if (pwm[k] && !prev[k]) begin
                    per_w[k] <= cnt[k];
                    cnt[k] <= 8'h01;
                    hc[k] <= 8'h01;
                    n_rise[k] <= n_rise[k] + 8'h01;
                end
                if (!pwm[k] && prev[k]) hi_w[k] <= hc[k];
            end
        end
    end
endmodule : pwt_load
`default_nettype wire

/* dv/tb_pwm_timer_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pwt_defs.svh"
module tb_pwm_timer_unit;
    import pwt_pkg::*;
    typedef struct packed {
        logic wr; pwt_addr_t a; pwt_word_t d; logic [3:0] s; pwt_word_t e; logic [1:0] r;
    } pwt_row_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    pwt_addr_t awaddr = '0;
    pwt_addr_t araddr = '0;
    pwt_word_t wdata = '0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
    logic [3:0] cap_in = '0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, rs;
    pwt_word_t rdata, rd, v;
    logic [5:0] pwm_out;
    logic [5:0][7:0] per_w, hi_w, n_rise;
    int n_errors = 0;
    int total_checks = 0;
    int n;
    pwt_row_t rows [10] = '{
        '{1'b0, 8'h04, 32'h0, 4'hF, 32'h0, 2'h0},
        '{1'b0, 8'h0C, 32'h0, 4'hF, 32'h0, 2'h0},
        '{1'b0, 8'h00, 32'h0, 4'hF, 32'h0, 2'h0},
        '{1'b0, 8'h20, 32'h0, 4'hF, 32'h0, 2'h0},
        '{1'b1, 8'h08, 32'h3, 4'hF, 32'h3, 2'h0},
        '{1'b1, 8'h08, 32'hFFFF_FFFF, 4'h2, 32'h0000_FF03, 2'h0},
        '{1'b1, 8'h58, 32'h89AB_CDEF, 4'hF, 32'h89AB_CDEF, 2'h0},
        '{1'b1, 8'h04, 32'hFF, 4'hF, 32'h0, 2'h0},
        '{1'b1, 8'h30, 32'h5A, 4'hF, 32'h0, 2'h2},
        '{1'b0, 8'h02, 32'h0, 4'hF, 32'h0, 2'h2}
    };
    pwt_top u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cap_in(cap_in), .pwm_out(pwm_out), .irq(irq)
    );
    pwt_load u_load (
        .aclk(aclk), .aresetn(aresetn), .pwm(pwm_out),
        .per_w(per_w), .hi_w(hi_w), .n_rise(n_rise)
    );
    initial begin
        forever #2.5 aclk = ~aclk;
    end
    // ----------------------------------------
    // bus tasks and checking
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    task automatic axw(input pwt_addr_t a, input pwt_word_t d, input logic [3:0] s,
                       output logic [1:0] r);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
    endtask : axw
    task automatic axr(input pwt_addr_t a, output pwt_word_t d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask : axr
    task automatic wr(input pwt_addr_t a, input pwt_word_t d);
        axw(a, d, 4'hF, rs);
    endtask : wr
    task automatic rchk(input pwt_addr_t a, input pwt_word_t e);
        axr(a, rd, rs);
        check(rd, e);
    endtask : rchk
    function automatic pwt_addr_t mra(input int i);
        return {`PWT_A_MR_HI, 3'(i), 2'b00};
    endfunction : mra
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        check(32'(pwm_out), 32'h0);
        check(32'(irq), 32'h0);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axw(rows[i].a, rows[i].d, rows[i].s, rs);
                check(32'(rs), 32'(rows[i].r));
            end
            axr(rows[i].a, rd, rs);
            check(rd, rows[i].e);
            check(32'(rs), 32'(rows[i].r));
        end
        // timer mode: stop with interrupt on match 0
        wr(`PWT_A_PR, 32'h0);
        wr(mra(0), 32'h5);
        wr(`PWT_A_MCR, 32'h5);
        wr(`PWT_A_IMSK, 32'h1);
        wr(`PWT_A_CTRL, 32'h1);
        n = 0;
        while (irq !== 1'b1 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        check(32'(irq), 32'h1);
        rchk(`PWT_A_CTRL, 32'h0);
        wr(`PWT_A_IMSK, 32'h0);
        check(32'(irq), 32'h0);
        rchk(`PWT_A_IST, 32'h1);
        wr(`PWT_A_IMSK, 32'h1);
        check(32'(irq), 32'h1);
        wr(`PWT_A_IST, 32'h1);
        check(32'(irq), 32'h0);
        rchk(`PWT_A_IST, 32'h0);
        // capture 0 on rise with flag, capture 1 on fall without
        wr(`PWT_A_CCR, 32'h15);
        wr(`PWT_A_IMSK, 32'h300);
        axr(`PWT_A_TC, v, rs);
        cap_in <= 4'h3;
        repeat (3) @(posedge aclk);
        cap_in <= 4'h1;
        repeat (3) @(posedge aclk);
        rchk(`PWT_A_IST, 32'h100);
        rchk({`PWT_A_CR_HI, 5'h00}, v);
        rchk({`PWT_A_CR_HI, 5'h04}, v);
        check(32'(irq), 32'h1);
        // timer mode: reset on match 1 keeps the count at or below it
        wr(mra(1), 32'h3);
        wr(`PWT_A_MCR, 32'h10);
        wr(`PWT_A_CTRL, 32'h2);
        wr(`PWT_A_CTRL, 32'h1);
        repeat (20) @(posedge aclk);
        axr(`PWT_A_TC, rd, rs);
        check(32'(rd <= 32'h3), 32'h1);
        // pwm: single output 1, double output 2, constant low output 3
        wr(`PWT_A_IST, 32'hFFF);
        wr(`PWT_A_MCR, 32'h0);
        wr(`PWT_A_CTRL, 32'h2);
        wr(`PWT_A_PR, 32'h1);
        wr(mra(1), 32'h2);
        wr(mra(2), 32'h5);
        wr(mra(3), 32'h0);
        wr(mra(0), 32'h7);
        wr(`PWT_A_PCR, 32'hE04);
        wr(`PWT_A_CTRL, 32'h9);
        repeat (60) @(posedge aclk);
        check(32'(per_w[0]), 32'((7 + 1) * (1 + 1)));
        check(32'(per_w[1]), 32'((7 + 1) * (1 + 1)));
        check(32'(hi_w[0]), 32'((2 + 1) * 2));
        check(32'(hi_w[1]), 32'((5 - 2) * 2));
        wr(mra(1), 32'h5);
        wr(mra(2), 32'h2);
        repeat (60) @(posedge aclk);
        check(32'(hi_w[0]), 32'((2 + 1) * 2));
        rchk(mra(1), 32'h5);
        wr(`PWT_A_LER, 32'h6);
        repeat (60) @(posedge aclk);
        check(32'(hi_w[0]), 32'((5 + 1) * 2));
        check(32'(hi_w[1]), 32'((7 + 1 - 5 + 2) * 2));
        rchk(`PWT_A_LER, 32'h0);
        check(32'(n_rise[2]), 32'h0);
        check(32'(pwm_out[5:3]), 32'h0);
        // second reset in mid-run
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        check(32'(pwm_out), 32'h0);
        rchk(`PWT_A_CTRL, 32'h0);
        rchk(`PWT_A_TC, 32'h0);
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        finish_test();
    end
endmodule : tb_pwm_timer_unit
`default_nettype wire
